// file: src/vec_pkg.sv
// Operation
// - Any sources may share the fast request
// - Software reads fast status to find sources
// - Software should class only one source fast
// - Status bits follow request lines combinationally
// - Core writes active vector address before return
// - That write releases the held vector address
// - Ones in enable clear drop enables
// - Ones in request clear drop software requests
// - A clear one acts once, rewrite zero first
// - Uncleared sources are disabled via enable clear
// - Zero class bit routes source to normal
// - One in enable bit enables the source
// - Slot control: enable bit 5, source low
// - Lower slot number wins priority
// - Vectored winner returns its slot handler address
// - Requests with no enabled slot hit return default address
// - Vanished request returns default address
package vec_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int SRC_N      = 32;
  localparam int SLOT_N     = 16;
  localparam int SLOT_IDX_W = 4;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int USER_AW    = 8;

  // ****************************************
  // Device register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_NORMAL_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_FAST_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_RAW_STATUS    = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_CLASS_SELECT  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_MASK   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ENABLE_CLEAR  = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_SW_REQUEST    = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_SW_REQ_CLEAR  = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE_VECTOR = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_DEFAULT_ADDR  = 12'h034;
  localparam logic [3:0]        PAGE_SLOT_ADDR    = 4'h1;
  localparam logic [3:0]        PAGE_SLOT_CTRL    = 4'h2;

  // ****************************************
  // Slot control fields and resets
  // ****************************************
  localparam int SLOT_EN_BIT  = 5;
  localparam int SLOT_SRC_W   = 5;
  localparam int SLOT_CTRL_W  = 6;
  localparam logic [DATA_W-1:0]      RST_WORD = 32'h0000_0000;
  localparam logic [SLOT_CTRL_W-1:0] RST_CTRL = 6'h00;

  // ****************************************
  // Host controller offsets and bits
  // ****************************************
  localparam logic [USER_AW-1:0] H_CMD_ADDR = 8'h00;
  localparam logic [USER_AW-1:0] H_CMD_DATA = 8'h04;
  localparam logic [USER_AW-1:0] H_CMD_GO   = 8'h08;
  localparam logic [USER_AW-1:0] H_RESULT   = 8'h0C;
  localparam logic [USER_AW-1:0] H_STATUS   = 8'h10;
  localparam logic [USER_AW-1:0] H_INT_STAT = 8'h14;
  localparam logic [USER_AW-1:0] H_INT_MASK = 8'h18;
  localparam int GO_READ_BIT = 0;
  localparam int EV_DONE     = 0;
  localparam int EV_NORMAL   = 1;
  localparam int EV_FAST     = 2;
  localparam int EV_W        = 3;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b001,
    H_STROBE = 3'b010,
    H_FETCH  = 3'b100
  } vec_host_state_t;

endpackage

// file: src/vec_link_if.sv
`timescale 1ns/1ns
interface vec_link_if;
  import vec_pkg::*;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata;
  logic              regWrite;
  logic              regRead;
  logic [DATA_W-1:0] regRdata;
  logic              normalIntReq;
  logic              fastIntReq;

  modport core (output regAddr, regWdata, regWrite, regRead,
                input regRdata, normalIntReq, fastIntReq);
  modport ctrl (input regAddr, regWdata, regWrite, regRead,
                output regRdata, normalIntReq, fastIntReq);
endinterface

// file: src/vec_slot.sv
`timescale 1ns/1ns
module vec_slot
  import vec_pkg::*;
(
  // Slot setup
  input  wire logic [SLOT_CTRL_W-1:0] slotCtrl,
  // Request view
  input  wire logic [SRC_N-1:0]       normalStatus,
  output logic                        hit
);
  // Enable bit plus source index select one normal request
  assign hit = slotCtrl[SLOT_EN_BIT] & normalStatus[slotCtrl[SLOT_SRC_W-1:0]];
endmodule

// file: src/vec_controller.sv
`timescale 1ns/1ns
module vec_controller
  import vec_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Peripheral request lines
  input  wire logic [SRC_N-1:0] periphReq,
  // Core link
  vec_link_if.ctrl          link
);

  // ****************************************
  // State
  // ****************************************
  logic [SRC_N-1:0]       enable_reg,    enable_next;
  logic [SRC_N-1:0]       class_reg,     class_next;
  logic [SRC_N-1:0]       softReq_reg,   softReq_next;
  logic [SRC_N-1:0]       enClrLast_reg, enClrLast_next;
  logic [SRC_N-1:0]       swClrLast_reg, swClrLast_next;
  logic [DATA_W-1:0]      defAddr_reg,   defAddr_next;
  logic [DATA_W-1:0]      slotAddr_reg   [SLOT_N];
  logic [DATA_W-1:0]      slotAddr_next  [SLOT_N];
  logic [SLOT_CTRL_W-1:0] slotCtrl_reg   [SLOT_N];
  logic [SLOT_CTRL_W-1:0] slotCtrl_next  [SLOT_N];
  logic                   held_reg,      held_next;
  logic [DATA_W-1:0]      heldAddr_reg,  heldAddr_next;
  logic [DATA_W-1:0]      rdata_reg,     rdata_next;
  logic                   normal_reg,    normal_next;
  logic                   fast_reg,      fast_next;

  // ****************************************
  // Request view
  // ****************************************
  logic [SRC_N-1:0]      rawStatus;
  logic [SRC_N-1:0]      fastStatus;
  logic [SRC_N-1:0]      normalStatus;
  logic [SLOT_N-1:0]     slotHit;
  logic                  anyHit;
  logic [SLOT_IDX_W-1:0] winSlot;
  logic [DATA_W-1:0]     vecAddr;
  logic [SLOT_IDX_W-1:0] slotSel;

  // Clearing a peripheral flag drops all three views in the same cycle
  assign rawStatus    = periphReq | softReq_reg;
  assign fastStatus   = rawStatus & enable_reg & class_reg;
  assign normalStatus = rawStatus & enable_reg & ~class_reg;
  assign slotSel      = link.regAddr[SLOT_IDX_W+1:2];

  genvar g;
  generate
    for (g = 0; g < SLOT_N; g++)
    begin : gSlot
      vec_slot uSlot (
        .slotCtrl     (slotCtrl_reg[g]),
        .normalStatus (normalStatus),
        .hit          (slotHit[g])
      );
    end
  endgenerate

  // ****************************************
  // Priority pick
  // ****************************************
  always_comb
  begin
    anyHit  = 1'b0;
    winSlot = '0;
    for (int i = SLOT_N - 1; i >= 0; i--)
    begin
      if (slotHit[i])
      begin
        anyHit  = 1'b1;
        winSlot = SLOT_IDX_W'(i);
      end
    end
    // A request that vanished before the read leaves no hit, so default
    vecAddr = anyHit ? slotAddr_reg[winSlot] : defAddr_reg;
  end

  // ****************************************
  // Register access
  // ****************************************
  always_comb
  begin
    enable_next    = enable_reg;
    class_next     = class_reg;
    softReq_next   = softReq_reg;
    enClrLast_next = enClrLast_reg;
    swClrLast_next = swClrLast_reg;
    defAddr_next   = defAddr_reg;
    slotAddr_next  = slotAddr_reg;
    slotCtrl_next  = slotCtrl_reg;
    held_next      = held_reg;
    heldAddr_next  = heldAddr_reg;
    rdata_next     = RST_WORD;
    normal_next    = |normalStatus;
    fast_next      = |fastStatus;

    if (link.regWrite)
    begin
      if (link.regAddr == OFF_CLASS_SELECT)
        class_next = link.regWdata;
      else if (link.regAddr == OFF_ENABLE_MASK)
        enable_next = enable_reg | link.regWdata;
      else if (link.regAddr == OFF_ENABLE_CLEAR)
      begin
        // A held one clears only on its first write
        enable_next    = enable_reg & ~(link.regWdata & ~enClrLast_reg);
        enClrLast_next = link.regWdata;
      end
      else if (link.regAddr == OFF_SW_REQUEST)
        softReq_next = softReq_reg | link.regWdata;
      else if (link.regAddr == OFF_SW_REQ_CLEAR)
      begin
        softReq_next   = softReq_reg & ~(link.regWdata & ~swClrLast_reg);
        swClrLast_next = link.regWdata;
      end
      else if (link.regAddr == OFF_ACTIVE_VECTOR)
        held_next = 1'b0;
      else if (link.regAddr == OFF_DEFAULT_ADDR)
        defAddr_next = link.regWdata;
      else if (link.regAddr[ADDR_W-1:8] == PAGE_SLOT_ADDR)
        slotAddr_next[slotSel] = link.regWdata;
      else if (link.regAddr[ADDR_W-1:8] == PAGE_SLOT_CTRL)
        slotCtrl_next[slotSel] = link.regWdata[SLOT_CTRL_W-1:0];
    end

    if (link.regRead)
    begin
      if (link.regAddr == OFF_NORMAL_STATUS)
        rdata_next = normalStatus;
      else if (link.regAddr == OFF_FAST_STATUS)
        rdata_next = fastStatus;
      else if (link.regAddr == OFF_RAW_STATUS)
        rdata_next = rawStatus;
      else if (link.regAddr == OFF_CLASS_SELECT)
        rdata_next = class_reg;
      else if (link.regAddr == OFF_ENABLE_MASK)
        rdata_next = enable_reg;
      else if (link.regAddr == OFF_SW_REQUEST)
        rdata_next = softReq_reg;
      else if (link.regAddr == OFF_ACTIVE_VECTOR)
      begin
        // Freeze the answer so a later, higher request cannot change it
        if (held_reg)
          rdata_next = heldAddr_reg;
        else
        begin
          rdata_next    = vecAddr;
          held_next     = 1'b1;
          heldAddr_next = vecAddr;
        end
      end
      else if (link.regAddr == OFF_DEFAULT_ADDR)
        rdata_next = defAddr_reg;
      else if (link.regAddr[ADDR_W-1:8] == PAGE_SLOT_ADDR)
        rdata_next = slotAddr_reg[slotSel];
      else if (link.regAddr[ADDR_W-1:8] == PAGE_SLOT_CTRL)
        rdata_next = {{(DATA_W-SLOT_CTRL_W){1'b0}}, slotCtrl_reg[slotSel]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable_reg    <= RST_WORD;
      class_reg     <= RST_WORD;
      softReq_reg   <= RST_WORD;
      enClrLast_reg <= RST_WORD;
      swClrLast_reg <= RST_WORD;
      defAddr_reg   <= RST_WORD;
      for (int i = 0; i < SLOT_N; i++)
      begin
        slotAddr_reg[i] <= RST_WORD;
        slotCtrl_reg[i] <= RST_CTRL;
      end
      held_reg      <= 1'b0;
      heldAddr_reg  <= RST_WORD;
      rdata_reg     <= RST_WORD;
      normal_reg    <= 1'b0;
      fast_reg      <= 1'b0;
    end
    else
    begin
      enable_reg    <= enable_next;
      class_reg     <= class_next;
      softReq_reg   <= softReq_next;
      enClrLast_reg <= enClrLast_next;
      swClrLast_reg <= swClrLast_next;
      defAddr_reg   <= defAddr_next;
      slotAddr_reg  <= slotAddr_next;
      slotCtrl_reg  <= slotCtrl_next;
      held_reg      <= held_next;
      heldAddr_reg  <= heldAddr_next;
      rdata_reg     <= rdata_next;
      normal_reg    <= normal_next;
      fast_reg      <= fast_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.regRdata     = rdata_reg;
  assign link.normalIntReq = normal_reg;
  assign link.fastIntReq   = fast_reg;

endmodule

// file: src/vec_core_host.sv
`timescale 1ns/1ns
module vec_core_host
  import vec_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Software port
  input  wire logic [USER_AW-1:0] uAddr,
  input  wire logic [DATA_W-1:0]  uWdata,
  input  wire logic               uWrite,
  input  wire logic               uRead,
  output logic [DATA_W-1:0]       uRdata,
  output logic                    irq,
  // Controller link
  vec_link_if.core                link
);

  // ****************************************
  // State
  // ****************************************
  vec_host_state_t    state_reg,    state_next;
  logic [ADDR_W-1:0]  cmdAddr_reg,  cmdAddr_next;
  logic [DATA_W-1:0]  cmdData_reg,  cmdData_next;
  logic               busRd_reg,    busRd_next;
  logic               busWr_reg,    busWr_next;
  logic [DATA_W-1:0]  result_reg,   result_next;
  logic [EV_W-1:0]    intStat_reg,  intStat_next;
  logic [EV_W-1:0]    intMask_reg,  intMask_next;
  logic               irq_reg,      irq_next;
  logic [DATA_W-1:0]  uRdata_reg,   uRdata_next;
  logic               prevN_reg,    prevF_reg;
  logic [EV_W-1:0]    events;

  // Link levels come from the controller's flops on this clock: no synchroniser
  assign events = {link.fastIntReq & ~prevF_reg, link.normalIntReq & ~prevN_reg,
                   state_reg == H_FETCH};

  always_comb
  begin
    state_next   = state_reg;
    cmdAddr_next = cmdAddr_reg;
    cmdData_next = cmdData_reg;
    busRd_next   = 1'b0;
    busWr_next   = 1'b0;
    result_next  = result_reg;
    intMask_next = intMask_reg;
    uRdata_next  = RST_WORD;
    intStat_next = intStat_reg;

    case (state_reg)
      H_IDLE:
        if (uWrite && uAddr == H_CMD_GO)
        begin
          // The acknowledge is a write of any value to the active vector offset
          busRd_next = uWdata[GO_READ_BIT];
          busWr_next = ~uWdata[GO_READ_BIT];
          state_next = H_STROBE;
        end
      H_STROBE:
        state_next = H_FETCH;
      H_FETCH:
      begin
        // Read data stand only in this cycle
        result_next = link.regRdata;
        state_next  = H_IDLE;
      end
      default:
        state_next = H_IDLE;
    endcase

    if (uWrite)
    begin
      if (uAddr == H_CMD_ADDR)
        cmdAddr_next = uWdata[ADDR_W-1:0];
      else if (uAddr == H_CMD_DATA)
        cmdData_next = uWdata;
      else if (uAddr == H_INT_MASK)
        intMask_next = uWdata[EV_W-1:0];
    end

    if (uRead)
    begin
      if (uAddr == H_CMD_ADDR)
        uRdata_next = {{(DATA_W-ADDR_W){1'b0}}, cmdAddr_reg};
      else if (uAddr == H_CMD_DATA)
        uRdata_next = cmdData_reg;
      else if (uAddr == H_RESULT)
        uRdata_next = result_reg;
      else if (uAddr == H_STATUS)
        uRdata_next = {29'h0000_0000, link.fastIntReq, link.normalIntReq,
                       state_reg != H_IDLE};
      else if (uAddr == H_INT_STAT)
      begin
        uRdata_next  = {29'h0000_0000, intStat_reg};
        intStat_next = '0;
      end
      else if (uAddr == H_INT_MASK)
        uRdata_next = {29'h0000_0000, intMask_reg};
    end

    // Set wins over the read clear
    intStat_next = intStat_next | events;
    irq_next     = |(intStat_next & intMask_next);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg   <= H_IDLE;
      cmdAddr_reg <= '0;
      cmdData_reg <= RST_WORD;
      busRd_reg   <= 1'b0;
      busWr_reg   <= 1'b0;
      result_reg  <= RST_WORD;
      intStat_reg <= '0;
      intMask_reg <= '0;
      irq_reg     <= 1'b0;
      uRdata_reg  <= RST_WORD;
      prevN_reg   <= 1'b0;
      prevF_reg   <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cmdAddr_reg <= cmdAddr_next;
      cmdData_reg <= cmdData_next;
      busRd_reg   <= busRd_next;
      busWr_reg   <= busWr_next;
      result_reg  <= result_next;
      intStat_reg <= intStat_next;
      intMask_reg <= intMask_next;
      irq_reg     <= irq_next;
      uRdata_reg  <= uRdata_next;
      prevN_reg   <= link.normalIntReq;
      prevF_reg   <= link.fastIntReq;
    end
  end

  assign link.regAddr  = cmdAddr_reg;
  assign link.regWdata = cmdData_reg;
  assign link.regRead  = busRd_reg;
  assign link.regWrite = busWr_reg;
  assign uRdata        = uRdata_reg;
  assign irq           = irq_reg;

endmodule

// file: tb/vec_link_checker.sv
`timescale 1ns/1ns
module vec_link_checker
  import vec_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Watched signals
  input wire logic [SRC_N-1:0]  periphReq,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              normalIntReq,
  input wire logic              fastIntReq
);
  // ****
  // Shadow of the writable state
  // ****
  logic [DATA_W-1:0] clsSel_reg, enMask_reg, swReq_reg, enClr_reg, swClr_reg, held_reg;
  logic [DATA_W-1:0] clsSel_next, enMask_next, swReq_next, enClr_next, swClr_next, held_next;
  logic              heldOn_reg, heldOn_next, vecRd_reg, vecRd_next;
  logic [DATA_W-1:0] rawStat, normStat, fastStat;

  always_comb
  begin
    rawStat  = periphReq | swReq_reg;
    normStat = rawStat & enMask_reg & ~clsSel_reg;
    fastStat = rawStat & enMask_reg & clsSel_reg;
    {clsSel_next, enMask_next, swReq_next, enClr_next, swClr_next, held_next, heldOn_next} =
      {clsSel_reg, enMask_reg, swReq_reg, enClr_reg, swClr_reg, held_reg, heldOn_reg};
    vecRd_next = regRead && (regAddr == OFF_ACTIVE_VECTOR);
    // Capture first, so an acknowledge right after the read still releases the hold
    if (vecRd_reg)
    begin
      heldOn_next = 1'b1;
      held_next   = regRdata;
    end
    // A clear bit only acts if it was zero in the previous write there
    if (regWrite)
    begin
      case (regAddr)
        OFF_CLASS_SELECT:  clsSel_next = regWdata;
        OFF_ENABLE_MASK:   enMask_next = enMask_reg | regWdata;
        OFF_ENABLE_CLEAR:  enMask_next = enMask_reg & ~(regWdata & ~enClr_reg);
        OFF_SW_REQUEST:    swReq_next = swReq_reg | regWdata;
        OFF_SW_REQ_CLEAR:  swReq_next = swReq_reg & ~(regWdata & ~swClr_reg);
        OFF_ACTIVE_VECTOR: heldOn_next = 1'b0;
        default:           ;
      endcase
      if (regAddr == OFF_ENABLE_CLEAR)
        enClr_next = regWdata;
      if (regAddr == OFF_SW_REQ_CLEAR)
        swClr_next = regWdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      {clsSel_reg, enMask_reg, swReq_reg, enClr_reg, swClr_reg, held_reg, heldOn_reg,
        vecRd_reg} <= '0;
    else
      {clsSel_reg, enMask_reg, swReq_reg, enClr_reg, swClr_reg, held_reg, heldOn_reg,
        vecRd_reg} <= {clsSel_next, enMask_next, swReq_next, enClr_next, swClr_next,
        held_next, heldOn_next, vecRd_next};
  end

  // ****
  // Assertions
  // ****
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    !$past(regRead) |-> regRdata == '0) else $error("read data not idle");
  AST_NORMAL_LEVEL: assert property (@(posedge clk) disable iff (rst)
    normalIntReq == $past(|normStat)) else $error("normal request level wrong");
  AST_FAST_LEVEL: assert property (@(posedge clk) disable iff (rst)
    fastIntReq == $past(|fastStat)) else $error("fast request level wrong");
  AST_NORMAL_READ: assert property (@(posedge clk) disable iff (rst)
    $past(regRead && regAddr == OFF_NORMAL_STATUS) |-> regRdata == $past(normStat))
    else $error("normal status read wrong");
  AST_FAST_READ: assert property (@(posedge clk) disable iff (rst)
    $past(regRead && regAddr == OFF_FAST_STATUS) |-> regRdata == $past(fastStat))
    else $error("fast status read wrong");
  AST_RAW_READ: assert property (@(posedge clk) disable iff (rst)
    $past(regRead && regAddr == OFF_RAW_STATUS) |-> regRdata == $past(rawStat))
    else $error("raw status read wrong");
  AST_ENABLE_READ: assert property (@(posedge clk) disable iff (rst)
    $past(regRead && regAddr == OFF_ENABLE_MASK) |-> regRdata == $past(enMask_reg))
    else $error("enable read wrong");
  AST_SWREQ_READ: assert property (@(posedge clk) disable iff (rst)
    $past(regRead && regAddr == OFF_SW_REQUEST) |-> regRdata == $past(swReq_reg))
    else $error("software request read wrong");
  AST_VECTOR_HELD: assert property (@(posedge clk) disable iff (rst)
    $past(vecRd_next && heldOn_reg) |-> regRdata == $past(held_reg))
    else $error("held vector changed");
endmodule

// file: tb/vectored_interrupt_controller_tb_top.sv
`timescale 1ns/1ns
module vectored_interrupt_controller_tb_top;
  import vec_pkg::*;
  localparam logic [DATA_W-1:0] DEF_ADDR = 32'h0000_0D00;
  logic               clk, rst, uWrite, uRead, irq;
  logic [USER_AW-1:0] uAddr;
  logic [DATA_W-1:0]  uWdata, uRdata, rd;
  logic [SRC_N-1:0]   periphReq;
  int                 mismatches, checked;

  vec_link_if vec_link_if_i ();
  vec_controller vec_controller_i (.clk(clk), .rst(rst), .periphReq(periphReq),
    .link(vec_link_if_i.ctrl));
  vec_core_host vec_core_host_i (.clk(clk), .rst(rst), .uAddr(uAddr), .uWdata(uWdata),
    .uWrite(uWrite), .uRead(uRead), .uRdata(uRdata), .irq(irq), .link(vec_link_if_i.core));
  vec_link_checker vec_link_checker_i (.clk(clk), .rst(rst), .periphReq(periphReq),
    .regAddr(vec_link_if_i.regAddr), .regWdata(vec_link_if_i.regWdata),
    .regWrite(vec_link_if_i.regWrite), .regRead(vec_link_if_i.regRead),
    .regRdata(vec_link_if_i.regRdata), .normalIntReq(vec_link_if_i.normalIntReq),
    .fastIntReq(vec_link_if_i.fastIntReq));

  // ****
  // Access tasks
  // ****
  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Each access leaves one idle edge so a strobe is never set twice in a step
  task automatic hostWrite(input logic [USER_AW-1:0] a, input logic [DATA_W-1:0] d);
    uAddr  <= a;
    uWdata <= d;
    uWrite <= 1'b1;
    @(posedge clk);
    uWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic hostRead(input logic [USER_AW-1:0] a, output logic [DATA_W-1:0] d);
    uAddr <= a;
    uRead <= 1'b1;
    @(posedge clk);
    uRead <= 1'b0;
    @(posedge clk);
    d = uRdata;
  endtask

  task automatic devGo(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic rdOp);
    logic [DATA_W-1:0] s;
    hostWrite(H_CMD_ADDR, {20'h00000, a});
    hostWrite(H_CMD_DATA, d);
    hostWrite(H_CMD_GO, {31'h00000000, rdOp});
    for (int i = 0; i < 20; i++)
    begin
      hostRead(H_STATUS, s);
      if (s[0] === 1'b0)
        return;
    end
    mismatches++;
    $display("mismatch busy expected 0 seen 1");
    results();
  endtask

  task automatic devCheck(input string what, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp);
    devGo(a, 32'h0000_0000, 1'b1);
    hostRead(H_RESULT, rd);
    check(what, rd, exp);
  endtask

  // ****
  // Clock and tests
  // ****
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    {rst, uWrite, uRead, uAddr, uWdata, periphReq, mismatches, checked} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    devGo(12'h040, 32'hFFFF_FFFF, 1'b0);
    devCheck("unmapped", 12'h040, 32'h0000_0000);
    devCheck("enable", OFF_ENABLE_MASK, 32'h0000_0000);
    $display("test reset done");
    devGo(OFF_CLASS_SELECT, 32'h0000_0000, 1'b0);
    devGo(OFF_ENABLE_MASK, 32'h0000_06C0, 1'b0);
    devGo(OFF_DEFAULT_ADDR, DEF_ADDR, 1'b0);
    devGo(12'h100, 32'h0000_0A00, 1'b0);
    devGo(12'h104, 32'h0000_0B00, 1'b0);
    devGo(12'h108, 32'h0000_0C00, 1'b0);
    devGo(12'h200, 32'h0000_0026, 1'b0);
    devGo(12'h204, 32'h0000_002A, 1'b0);
    devGo(12'h208, 32'h0000_0009, 1'b0);
    periphReq <= 32'h0000_0200;
    devCheck("normal status", OFF_NORMAL_STATUS, 32'h0000_0200);
    devCheck("default vector", OFF_ACTIVE_VECTOR, DEF_ADDR);
    devGo(OFF_ACTIVE_VECTOR, 32'h0000_0000, 1'b0);
    periphReq <= 32'h0000_0640;
    devCheck("slot0 vector", OFF_ACTIVE_VECTOR, 32'h0000_0A00);
    periphReq <= 32'h0000_0600;
    devCheck("held vector", OFF_ACTIVE_VECTOR, 32'h0000_0A00);
    devGo(OFF_ACTIVE_VECTOR, 32'h0000_0000, 1'b0);
    devCheck("slot1 vector", OFF_ACTIVE_VECTOR, 32'h0000_0B00);
    devGo(OFF_ACTIVE_VECTOR, 32'h0000_0000, 1'b0);
    periphReq <= 32'h0000_0000;
    devCheck("vanished", OFF_ACTIVE_VECTOR, DEF_ADDR);
    devGo(OFF_ACTIVE_VECTOR, 32'h0000_0000, 1'b0);
    $display("test vectoring done");
    devGo(OFF_CLASS_SELECT, 32'h0000_0018, 1'b0);
    devGo(OFF_ENABLE_MASK, 32'h0000_0018, 1'b0);
    periphReq <= 32'h0000_0038;
    devCheck("raw", OFF_RAW_STATUS, 32'h0000_0038);
    devCheck("fast", OFF_FAST_STATUS, 32'h0000_0018);
    devCheck("normal", OFF_NORMAL_STATUS, 32'h0000_0000);
    hostRead(H_STATUS, rd);
    check("link levels", rd & 32'h0000_0006, 32'h0000_0004);
    periphReq <= 32'h0000_0020;
    devCheck("fast dropped", OFF_FAST_STATUS, 32'h0000_0000);
    devGo(OFF_ENABLE_CLEAR, 32'h0000_0008, 1'b0);
    devCheck("enable", OFF_ENABLE_MASK, 32'h0000_06D0);
    $display("test status done");
    devGo(OFF_SW_REQUEST, 32'h0000_0005, 1'b0);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0001, 1'b0);
    devCheck("swreq", OFF_SW_REQUEST, 32'h0000_0004);
    devGo(OFF_SW_REQUEST, 32'h0000_0001, 1'b0);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0001, 1'b0);
    devCheck("swreq", OFF_SW_REQUEST, 32'h0000_0005);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0000, 1'b0);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0005, 1'b0);
    devCheck("swreq", OFF_SW_REQUEST, 32'h0000_0000);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0000, 1'b0);
    $display("test software request done");
    hostWrite(H_INT_MASK, 32'h0000_0002);
    hostRead(H_INT_STAT, rd);
    devGo(OFF_SW_REQUEST, 32'h0000_0040, 1'b0);
    hostRead(H_STATUS, rd);
    check("normal level", rd & 32'h0000_0006, 32'h0000_0002);
    check("irq", {31'h00000000, irq}, 32'h0000_0001);
    hostRead(H_INT_STAT, rd);
    check("events", rd & 32'h0000_0006, 32'h0000_0002);
    devGo(OFF_SW_REQ_CLEAR, 32'h0000_0040, 1'b0);
    devGo(OFF_CLASS_SELECT, 32'h0000_0010, 1'b0);
    periphReq <= 32'h0000_0010;
    devCheck("fast", OFF_FAST_STATUS, 32'h0000_0010);
    hostRead(H_INT_STAT, rd);
    check("events", rd & 32'h0000_0006, 32'h0000_0004);
    check("irq masked", {31'h00000000, irq}, 32'h0000_0000);
    $display("test interrupt done");
    results();
  end
endmodule
